// file: tcio_regs.vh
// Register offsets, field positions, codes and reset values for the channel I/O control block
`ifndef TCIO_REGS_VH
`define TCIO_REGS_VH
`define TCIO_OFF_IO_HIGH     12'h000
`define TCIO_OFF_IO_LOW      12'h004
`define TCIO_OFF_MODE        12'h008
`define TCIO_OFF_STATUS      12'h00C
`define TCIO_RST_IO          8'h00
`define TCIO_RST_MODE        2'h0
`define TCIO_HI_CODE_B_MSB   7
`define TCIO_HI_CODE_B_LSB   4
`define TCIO_HI_CODE_A_MSB   3
`define TCIO_HI_CODE_A_LSB   0
`define TCIO_MODE_BUF_A_BIT  0
`define TCIO_MODE_BUF_B_BIT  1
`define TCIO_CAP_BIT         3
`define TCIO_INIT_BIT        2
`define TCIO_ACT_OFF         2'h0
`define TCIO_ACT_LOW         2'h1
`define TCIO_ACT_HIGH        2'h2
`define TCIO_ACT_TOGGLE      2'h3
`define TCIO_EDGE_RISE       2'h0
`define TCIO_EDGE_FALL       2'h1
`endif

// file: tcio_chan.v
// One general register's compare output and capture edge logic
`timescale 1ns/1ps
`default_nettype none
`include "tcio_regs.vh"
module tcio_chan (
    input  wire       ref_clk,
    input  wire       rst,
    input  wire [3:0] code,
    input  wire       blocked,
    input  wire       match,
    input  wire       pin_sync,
    output reg        pin_out_r,
    output reg        pin_oe_r,
    output reg        capture_r
);
    reg  [3:0] code_q_r;
    reg        pin_prev_r;
    wire       is_cap;
    wire       active;
    wire       rise;
    wire       fall;
    wire       edge_hit;
    reg        pin_nxt;

    assign is_cap = code[`TCIO_CAP_BIT];
    assign active = ~blocked;
    assign rise   = pin_sync & ~pin_prev_r;
    assign fall   = ~pin_sync & pin_prev_r;
    // R8: rising edge; R9: falling edge; R10: both edges
    assign edge_hit = (code[1:0] == `TCIO_EDGE_RISE) ? rise :
                      (code[1:0] == `TCIO_EDGE_FALL) ? fall : (rise | fall);

    always @* begin
        pin_nxt = pin_out_r;
        if (code != code_q_r) begin
            // R14: initial level placed when code changes
            pin_nxt = code[`TCIO_INIT_BIT];
        end else if (match) begin
            case (code[1:0])
                // R5: drive low on match
                `TCIO_ACT_LOW:    pin_nxt = 1'b0;
                // R6: drive high on match
                `TCIO_ACT_HIGH:   pin_nxt = 1'b1;
                // R7: invert on match
                `TCIO_ACT_TOGGLE: pin_nxt = ~pin_out_r;
                default:          pin_nxt = pin_out_r;
            endcase
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            code_q_r   <= 4'h0;
            pin_prev_r <= 1'b0;
            pin_out_r  <= 1'b0;
            pin_oe_r   <= 1'b0;
            capture_r  <= 1'b0;
        end else begin
            code_q_r   <= code;
            pin_prev_r <= pin_sync;
            // R11: buffer use blocks all function; R13: codes 0x00 leave pin undriven
            pin_oe_r   <= active & ~is_cap & (code[1:0] != `TCIO_ACT_OFF);
            // Disabled compare codes hold the pin low so out never shows without oe
            pin_out_r  <= (active & ~is_cap & (code[1:0] != `TCIO_ACT_OFF)) ? pin_nxt : 1'b0;
            // R12: no capture while used as buffer
            capture_r  <= active & is_cap & edge_hit;
        end
    end
endmodule
`default_nettype wire

// file: tcio_top.v
// APB control registers and four general register I/O functions for one timer channel
// Functional notes
// R1: High control bits 7..4 select register B function.
// R2: High control bits 3..0 select register A function.
// R3: Low control bits 7..4 select register D function.
// R4: Low control bits 3..0 select register C function.
// R5: Top bit clear means compare; x001 drives pin low, initial 0 or 1.
// R6: Codes x010 drive pin high on match, initial level from bit 2.
// R7: Codes x011 invert pin on match, initial level from bit 2.
// R8: Top bit set means capture; 1x00 captures on rising edge of pin.
// R9: Codes 1x01 capture on falling edge.
// R10: Codes 1x1x capture on both edges.
// R11: Buffer B enabled makes register D do nothing.
// R12: Buffer A enabled makes register C do nothing.
// R13: Codes reset to 0000; 0000 and 0100 leave pin undriven.
// R14: Selected initial level appears on pin before first match. Here a code written while buffered starts low when the buffer bit clears.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "tcio_regs.vh"
module tcio_top (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [3:0]  compare_match,
    input  wire [3:0]  timer_pin_in,
    output wire [3:0]  timer_pin_out,
    output wire [3:0]  timer_pin_oe,
    output wire [3:0]  capture_strobe
);
    reg  [7:0] io_control_high_r;
    reg  [7:0] io_control_low_r;
    reg  [1:0] channel_mode_reg_r;
    reg  [3:0] pin_s1_r;
    reg  [3:0] pin_s2_r;
    reg  [31:0] prdata_nxt;
    reg        decode_ok;
    wire       setup;
    wire       wr_lane0;
    wire [15:0] codes;
    wire [3:0] blocked;

    // Answer in the access cycle; pready registered high in setup so zero wait states
    assign setup    = psel & ~penable;
    assign wr_lane0 = psel & penable & pready & pwrite & pstrb[0];

    always @* begin
        prdata_nxt = 32'h0000_0000;
        decode_ok  = 1'b1;
        case (paddr)
            `TCIO_OFF_IO_HIGH: prdata_nxt = {24'h00_0000, io_control_high_r};
            `TCIO_OFF_IO_LOW:  prdata_nxt = {24'h00_0000, io_control_low_r};
            `TCIO_OFF_MODE:    prdata_nxt = {30'h0000_0000, channel_mode_reg_r};
            `TCIO_OFF_STATUS:  prdata_nxt = {24'h00_0000, timer_pin_oe, timer_pin_out};
            default:           decode_ok  = 1'b0;
        endcase
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~decode_ok;
            prdata  <= (setup & ~pwrite & decode_ok) ? prdata_nxt : 32'h0000_0000;
        end
    end

    // R13: codes reset to output disabled
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            io_control_high_r  <= `TCIO_RST_IO;
            io_control_low_r   <= `TCIO_RST_IO;
            channel_mode_reg_r <= `TCIO_RST_MODE;
        end else if (wr_lane0) begin
            case (paddr)
                `TCIO_OFF_IO_HIGH: io_control_high_r  <= pwdata[7:0];
                `TCIO_OFF_IO_LOW:  io_control_low_r   <= pwdata[7:0];
                `TCIO_OFF_MODE:    channel_mode_reg_r <= pwdata[1:0];
                default:           io_control_high_r  <= io_control_high_r;
            endcase
        end
    end

    // Pins are asynchronous to ref_clk
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end else begin
            pin_s1_r <= timer_pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // R2: A from high bits 3..0; R1: B from high bits 7..4
    // R4: C from low bits 3..0; R3: D from low bits 7..4
    assign codes = {io_control_low_r[7:4], io_control_low_r[3:0],
                    io_control_high_r[`TCIO_HI_CODE_B_MSB:`TCIO_HI_CODE_B_LSB],
                    io_control_high_r[`TCIO_HI_CODE_A_MSB:`TCIO_HI_CODE_A_LSB]};
    // R12: C as buffer; R11: D as buffer
    assign blocked = {channel_mode_reg_r[`TCIO_MODE_BUF_B_BIT], channel_mode_reg_r[`TCIO_MODE_BUF_A_BIT], 2'b00};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            tcio_chan u_chan (
                .ref_clk   (ref_clk),
                .rst       (rst),
                .code      (codes[gi*4 +: 4]),
                .blocked   (blocked[gi]),
                .match     (compare_match[gi]),
                .pin_sync  (pin_s2_r[gi]),
                .pin_out_r (timer_pin_out[gi]),
                .pin_oe_r  (timer_pin_oe[gi]),
                .capture_r (capture_strobe[gi])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// file: tcio_monitor.sv
// Bus and pin checks for the channel I/O block
`timescale 1ns/1ps
`default_nettype none
module tcio_monitor (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  timer_pin_in,
    input wire logic [3:0]  timer_pin_out,
    input wire logic [3:0]  timer_pin_oe,
    input wire logic [3:0]  capture_strobe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_ready_timing: assert property (psel && !penable |=> pready) else $error("ready late");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("ready unasked");
    chk_err_unmapped: assert property (pready && paddr > 12'h00C |-> pslverr) else $error("no error");
    chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000) else $error("data idle");
    chk_out_disabled: assert property ((timer_pin_out & ~timer_pin_oe) == 4'h0) else $error("out");
    chk_cap_exclusive: assert property ((capture_strobe & timer_pin_oe) == 4'h0) else $error("cap");
    // Strobe seen three samples after the new pin level is first sampled
    chk_cap_edge: assert property (|capture_strobe |->
        (capture_strobe & ~($past(timer_pin_in, 3) ^ $past(timer_pin_in, 4))) == 4'h0) else $error("edge");
endmodule
`default_nettype wire

// file: tcio_pin_model.sv
// Channel pins: block drives where enabled, else the outside level
`timescale 1ns/1ps
`default_nettype none
module tcio_pin_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] level,
    output logic      [3:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule
`default_nettype wire

// file: tcio_top_test.sv
// APB bench for the channel I/O block
`timescale 1ns/1ps
`default_nettype none
`include "tcio_regs.vh"
module tcio_top_test;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0]  pstrb = 4'hF, compare_match = 4'h0, level = 4'h0, pin_in, pin_out, pin_oe, cap;
    int          miscompares = 0, comparisons = 0, ncap, i, c;
    initial forever #4 ref_clk = ~ref_clk;
    tcio_top tcio_top_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_match(compare_match), .timer_pin_in(pin_in), .timer_pin_out(pin_out),
        .timer_pin_oe(pin_oe), .capture_strobe(cap));
    tcio_pin_model tcio_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .level(level), .pin_in(pin_in));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task run(input int n, input int k);
        repeat (n) begin
            @(posedge ref_clk);
            if (cap[k] === 1'b1) ncap++;
        end
    endtask
    task pulse(input int k);
        compare_match[k] <= 1;
        @(posedge ref_clk);
        compare_match[k] <= 0;
        run(2, k);
    endtask
    task final_report;
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100us;
        miscompares++;
        final_report;
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 0;
        for (i = 0; i < 16; i += 4) begin
            apb(0, 12'(i), 8'h00);
            chk(rd, 0);
        end
        apb(0, 12'h010, 8'h00);
        chk(err, 1);
        // Every output code on every register, two matches each
        for (i = 0; i < 4; i++)
            for (c = 0; c < 8; c++) begin
                apb(1, 12'(i / 2 * 4), 8'(c << (i % 2 * 4)));
                run(2, i);
                chk(pin_oe[i], c[1:0] != 0);
                chk(pin_out[i], c[1:0] != 0 && c[2]);
                pulse(i);
                chk(pin_out[i], c[1:0] == 2 || (c[1:0] == 3 && !c[2]));
                pulse(i);
                chk(pin_out[i], c[1:0] == 2 || (c[1:0] == 3 && c[2]));
            end
        apb(1, `TCIO_OFF_IO_HIGH, 8'h00);
        apb(1, `TCIO_OFF_IO_LOW, 8'h00);
        run(8, 0);
        for (c = 8; c < 16; c++) begin
            i = c % 4;
            apb(1, 12'(i / 2 * 4), 8'(c << (i % 2 * 4)));
            ncap = 0;
            level[i] <= 1;
            run(8, i);
            chk(ncap, c[1] || !c[0]);
            ncap = 0;
            level[i] <= 0;
            run(8, i);
            chk(ncap, c[1] || c[0]);
        end
        // Both buffer pairs on: C and D must stay idle
        apb(1, `TCIO_OFF_MODE, 8'h03);
        apb(1, `TCIO_OFF_IO_LOW, 8'h82);
        ncap = 0;
        level[3] <= 1;
        pulse(2);
        run(8, 3);
        chk(ncap, 0);
        chk(pin_oe[2], 0);
        apb(0, `TCIO_OFF_IO_LOW, 8'h00);
        chk(rd, 32'h0000_0082);
        final_report;
    end
endmodule
bind tcio_top tcio_monitor tcio_monitor_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin_in(timer_pin_in),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe), .capture_strobe(capture_strobe));
`default_nettype wire
